// ---- mid_decoder.sv ----
//
// Operation
// RULE_01: File operand is the low 7-bit field, addresses 0x00 to 0x7F.
// RULE_02: Destination bit 0 writes accumulator, 1 writes the addressed file register.
// RULE_03: Don't-care bits are ignored; either value decodes the same.
// RULE_04: Top bits 00 mean byte op: 4-bit code, destination bit, address.
// RULE_05: Codes 0100, 0110, 0101 are OR, XOR, AND with file; zero only.
// RULE_06: Codes 1101, 1100 rotate left, right through carry; carry only.
// RULE_07: Codes 1011, 1111 decrement, increment; no flags; skip on zero.
// RULE_08: Top bits 01 are bit ops; 00bb clears, 01bb sets, no flags.
// RULE_09: 10bb, 11bb skip next if bit clear, set; one or two cycles.
// RULE_10: 100 calls, 101 jumps to an 11-bit target; two cycles.
// RULE_11: Literal 111x adds, 110x subtracts accumulator from literal; C, DC, Z.
// RULE_12: Literal 1000, 1001, 1010 are OR, AND, XOR; zero only.
// RULE_13: 00xx loads literal, one cycle; 01xx returns with literal, two cycles.
// RULE_14: Fixed words end 0x63 standby, 0x64 watchdog kick; both touch status.
// RULE_15: PC change or true test costs two cycles, second one a no-op.
// RULE_16: A port operand is read from pin levels, not the output latch.
// RULE_17: Writing the timer register clears the prescaler when assigned to it.
// RULE_18: Codes 0111, 0010 add, subtract accumulator with file; C, DC, Z.
// RULE_19: 0x08 returns, 0x09 returns and re-enables interrupts; two cycles.
//
`timescale 1ns/1ps
`include "mid_params.svh"

module mid_decoder (
   input  wire logic                  clk,
   input  wire logic                  sys_rst,
   input  wire logic [13:0]           instr_word,
   input  wire logic                  instr_valid,
   input  wire logic [7:0]            file_latch_data,
   input  wire logic [7:0]            file_pin_data,
   input  wire logic                  file_is_io,
   input  wire logic                  prescaler_on_timer,
   output mid_pkg::mid_alu_type       alu_func_reg,
   output logic                       src_literal_reg,
   output logic [7:0]                 operand_reg,
   output logic [7:0]                 literal_reg,
   output logic [6:0]                 file_addr_reg,
   output logic [2:0]                 bit_idx_reg,
   output logic                       dest_file_reg,
   output logic                       dest_acc_reg,
   output logic                       upd_zero_reg,
   output logic                       upd_carry_reg,
   output logic                       upd_dc_reg,
   output logic                       skip_reg,
   output logic                       nop_cycle_reg,
   output logic                       jump_reg,
   output logic                       push_reg,
   output logic                       pop_reg,
   output logic                       int_enable_reg,
   output logic [10:0]                target_reg,
   output logic [1:0]                 cycles_reg,
   output logic                       sleep_req_reg,
   output logic                       watchdog_kick_reg,
   output logic                       timeout_flag_wr_reg,
   output logic                       powerdown_flag_wr_reg,
   output logic                       powerdown_flag_val_reg,
   output logic                       prescaler_clr_reg
);
   import mid_pkg::*;

   // ************************************************************
   // Field decode
   // ************************************************************
   mid_dec_if     dif ();
   mid_state_type state_reg;
   mid_state_type state_next;

   assign dif.word = instr_word;

   mid_word_decode u_dec (
      .dec (dif.dec)
   );

   // Timer register hit; kept as a function, though only the prescaler clear term uses it
   function automatic logic hits_timer(input logic [6:0] addr);
      hits_timer = (addr == `MID_TIMER_ADDR);
   endfunction

   // ************************************************************
   // Execute-cycle terms
   // ************************************************************
   // The word that follows a taken skip or branch was already fetched; it is dropped
   wire       exec_now  = instr_valid && (state_reg == MID_ST_RUN);
   wire [6:0] f_addr    = instr_word[`MID_FILE_HI:0];                     // [RULE_01]
   wire [2:0] b_idx     = instr_word[`MID_BIT_HI:`MID_BIT_LO];
   wire [7:0] operand   = file_is_io ? file_pin_data : file_latch_data; // [RULE_16]
   wire       bit_val   = operand[b_idx];
   wire       zero_hit  = (dif.alu_func == MID_ALU_DEC) ? (operand == `MID_DEC_HITS0)
                                                         : (operand == `MID_INC_HITS0);
   wire       skip_take = (dif.skip_on_zero && zero_hit) ||           // [RULE_07]
                          (dif.bit_test && (bit_val == dif.test_set)); // [RULE_09]
   wire       pc_change = dif.jump_op || dif.pop_pc;                  // [RULE_10] [RULE_19]
   wire       two_cyc   = skip_take || pc_change;                     // [RULE_15]
   wire       tmr_clear = dif.dest_file && hits_timer(f_addr) && prescaler_on_timer;

   // Sequencer: a two-cycle instruction forces exactly one no-op cycle
   always_comb begin
      case (state_reg)
         MID_ST_RUN:   state_next = (exec_now && two_cyc) ? MID_ST_FLUSH : MID_ST_RUN;
         MID_ST_FLUSH: state_next = MID_ST_RUN;                      // [RULE_15]
         default:      state_next = MID_ST_RUN;
      endcase
   end

   // ************************************************************
   // Output registers
   // ************************************************************
   // Sequencer state
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_reg <= MID_ST_RUN;
      end else begin
         state_reg <= state_next;
      end
   end

   // Operands and addresses; harmless to load on idle cycles
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         operand_reg   <= 8'h00;
         literal_reg   <= 8'h00;
         file_addr_reg <= 7'h00;
         bit_idx_reg   <= 3'h0;
         target_reg    <= 11'h000;
      end else begin
         operand_reg   <= operand;                                      // [RULE_16]
         literal_reg   <= instr_word[`MID_LIT_HI:0];
         file_addr_reg <= f_addr;                                       // [RULE_01]
         bit_idx_reg   <= b_idx;                                        // [RULE_08]
         target_reg    <= instr_word[`MID_TGT_HI:0];                    // [RULE_10]
      end
   end

   // Control strobes; all idle outside an execute cycle, so the no-op cycle is clean
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         alu_func_reg      <= MID_ALU_NONE;
         src_literal_reg   <= 1'b0;
         dest_file_reg     <= 1'b0;
         dest_acc_reg      <= 1'b0;
         upd_zero_reg      <= 1'b0;
         upd_carry_reg     <= 1'b0;
         upd_dc_reg        <= 1'b0;
         skip_reg          <= 1'b0;
         jump_reg          <= 1'b0;
         push_reg          <= 1'b0;
         pop_reg           <= 1'b0;
         int_enable_reg    <= 1'b0;
         sleep_req_reg     <= 1'b0;
         watchdog_kick_reg <= 1'b0;
         prescaler_clr_reg <= 1'b0;
      end else begin
         alu_func_reg      <= exec_now ? dif.alu_func : MID_ALU_NONE;
         src_literal_reg   <= exec_now && dif.src_literal;
         dest_file_reg     <= exec_now && dif.dest_file;                // [RULE_02]
         dest_acc_reg      <= exec_now && dif.dest_acc;                 // [RULE_02]
         upd_zero_reg      <= exec_now && dif.upd_zero;                 // [RULE_05] [RULE_12]
         upd_carry_reg     <= exec_now && dif.upd_carry;                // [RULE_06] [RULE_11]
         upd_dc_reg        <= exec_now && dif.upd_dc;                   // [RULE_11] [RULE_18]
         skip_reg          <= exec_now && skip_take;                    // [RULE_07] [RULE_09]
         jump_reg          <= exec_now && dif.jump_op;                  // [RULE_10]
         push_reg          <= exec_now && dif.call_op;
         pop_reg           <= exec_now && dif.pop_pc;                   // [RULE_13] [RULE_19]
         int_enable_reg    <= exec_now && dif.int_enable;               // [RULE_19]
         sleep_req_reg     <= exec_now && dif.sleep_op;                 // [RULE_14]
         watchdog_kick_reg <= exec_now && dif.watchdog_kick;            // [RULE_14]
         prescaler_clr_reg <= exec_now && tmr_clear;                    // [RULE_17]
      end
   end

   // Status side effects and cycle accounting
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         timeout_flag_wr_reg    <= 1'b0;
         powerdown_flag_wr_reg  <= 1'b0;
         powerdown_flag_val_reg <= 1'b0;
         nop_cycle_reg          <= 1'b0;
         cycles_reg             <= `MID_CYC_ONE;
      end else begin
         // Both words set the time-out flag; standby clears power-down, kick sets it
         timeout_flag_wr_reg    <= exec_now && (dif.sleep_op || dif.watchdog_kick);
         powerdown_flag_wr_reg  <= exec_now && (dif.sleep_op || dif.watchdog_kick);
         powerdown_flag_val_reg <= dif.watchdog_kick;                   // [RULE_14]
         nop_cycle_reg          <= (state_reg == MID_ST_FLUSH);         // [RULE_15]
         cycles_reg             <= two_cyc ? `MID_CYC_TWO : `MID_CYC_ONE;
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_file_addr_field: assert property ( // [RULE_01]
      exec_now |=> file_addr_reg == $past(instr_word[6:0]))
      else $error("file address not taken from low seven bits");
   a_dest_select: assert property ( // [RULE_02]
      exec_now && instr_word[13:12] == 2'h0 && instr_word[11:8] > 4'h1
      |=> dest_file_reg == $past(instr_word[7]) && dest_acc_reg != dest_file_reg)
      else $error("destination bit not honoured");
   a_xdc_ignored: assert property ( // [RULE_03]
      exec_now && instr_word[13:10] == 4'hc |=> alu_func_reg == MID_ALU_LOAD_LIT)
      else $error("literal load depends on a don't-care bit");
   a_logic_zero: assert property ( // [RULE_05]
      exec_now && instr_word[13:8] inside {6'h04, 6'h05, 6'h06}
      |=> upd_zero_reg && !upd_carry_reg && !upd_dc_reg)
      else $error("byte logic op flag set wrong");
   a_rotate_carry: assert property ( // [RULE_06]
      exec_now && instr_word[13:9] == 5'h06 |=> upd_carry_reg && !upd_zero_reg)
      else $error("rotate flag set wrong");
   a_dec_skip: assert property ( // [RULE_07]
      exec_now && instr_word[13:8] == 6'h0b && operand == 8'h01
      |=> skip_reg && !upd_zero_reg ##1 nop_cycle_reg)
      else $error("decrement to zero did not skip");
   a_bit_skip: assert property ( // [RULE_09]
      exec_now && instr_word[13:10] == 4'h7 && !bit_val |=> !skip_reg ##1 !nop_cycle_reg)
      else $error("bit test skipped while bit clear");
   a_jump_target: assert property ( // [RULE_10]
      exec_now && instr_word[13:11] == 3'h5
      |=> jump_reg && cycles_reg == 2'h2 && target_reg == $past(instr_word[10:0]))
      else $error("jump target or cycle count wrong");
   a_sub_literal: assert property ( // [RULE_11]
      exec_now && instr_word[13:9] == 5'h1e
      |=> alu_func_reg == MID_ALU_SUB && src_literal_reg && upd_carry_reg && upd_dc_reg)
      else $error("literal subtract decoded wrong");
   a_standby_status: assert property ( // [RULE_14]
      exec_now && instr_word == 14'h0063
      |=> sleep_req_reg && timeout_flag_wr_reg && !powerdown_flag_val_reg)
      else $error("standby status update wrong");
   a_nop_quiet: assert property ( // [RULE_15]
      nop_cycle_reg |-> !dest_file_reg && !dest_acc_reg && !jump_reg && !skip_reg)
      else $error("no-op cycle has side effects");
   a_pin_source: assert property ( // [RULE_16]
      exec_now && file_is_io |=> operand_reg == $past(file_pin_data))
      else $error("port operand not read from pins");
   a_timer_presc: assert property ( // [RULE_17]
      exec_now && instr_word[13:12] == 2'h0 && instr_word[7] && instr_word[11:8] > 4'h1
      && instr_word[6:0] == 7'h01 && prescaler_on_timer |=> prescaler_clr_reg)
      else $error("timer write did not clear prescaler");

   c_skip_taken: cover property (exec_now && skip_take ##1 skip_reg ##1 nop_cycle_reg);
   c_call:       cover property (exec_now && dif.call_op ##1 push_reg);
   c_return_ie:  cover property (exec_now && dif.int_enable ##1 pop_reg);
   c_presc_clr:  cover property (prescaler_clr_reg);

endmodule

// ---- mid_params.svh ----
`ifndef MID_PARAMS_SVH
`define MID_PARAMS_SVH

// ************************************************************
// Instruction word field positions
// ************************************************************
`define MID_CLASS_HI    13
`define MID_CLASS_LO    12
`define MID_OP_HI       11
`define MID_OP_LO       8
`define MID_DEST_BIT    7
`define MID_FILE_HI     6
`define MID_BIT_HI      9
`define MID_BIT_LO      7
`define MID_LIT_HI      7
`define MID_TGT_HI      10
`define MID_JUMP_SEL    11

// ************************************************************
// Instruction classes and fixed control words
// ************************************************************
`define MID_CLASS_BYTE  2'h0
`define MID_CLASS_BIT   2'h1
`define MID_CLASS_JUMP  2'h2
`define MID_CLASS_LIT   2'h3
`define MID_WORD_RET    14'h0008
`define MID_WORD_RETIE  14'h0009
`define MID_WORD_SLEEP  14'h0063
`define MID_WORD_WDT    14'h0064

// ************************************************************
// Addresses, operand constants and cycle counts
// ************************************************************
`define MID_TIMER_ADDR  7'h01
`define MID_DEC_HITS0   8'h01
`define MID_INC_HITS0   8'hff
`define MID_CYC_ONE     2'h1
`define MID_CYC_TWO     2'h2

`endif

// ---- mid_pkg.sv ----
package mid_pkg;

   // ALU function selected for the execute cycle
   typedef enum logic [4:0] {
      MID_ALU_NONE, MID_ALU_ADD, MID_ALU_SUB, MID_ALU_AND, MID_ALU_OR,
      MID_ALU_XOR, MID_ALU_INC, MID_ALU_DEC, MID_ALU_RL, MID_ALU_RR,
      MID_ALU_COM, MID_ALU_SWAP, MID_ALU_MOVE, MID_ALU_PASS_ACC,
      MID_ALU_LOAD_LIT, MID_ALU_CLEAR, MID_ALU_BIT_CLR, MID_ALU_BIT_SET
   } mid_alu_type;

   // Sequencer states, one-hot
   typedef enum logic [1:0] {
      MID_ST_RUN   = 2'b01,
      MID_ST_FLUSH = 2'b10
   } mid_state_type;

endpackage

// ---- mid_dec_if.sv ----
`timescale 1ns/1ps

// Decoded fields of one instruction word
interface mid_dec_if;
   import mid_pkg::*;
   logic [13:0]  word;
   mid_alu_type  alu_func;
   logic         src_literal;
   logic         dest_file;
   logic         dest_acc;
   logic         upd_zero;
   logic         upd_carry;
   logic         upd_dc;
   logic         skip_on_zero;
   logic         bit_test;
   logic         test_set;
   logic         jump_op;
   logic         call_op;
   logic         pop_pc;
   logic         int_enable;
   logic         sleep_op;
   logic         watchdog_kick;

   modport dec (input word, output alu_func, src_literal, dest_file, dest_acc, upd_zero,
                upd_carry, upd_dc, skip_on_zero, bit_test, test_set, jump_op, call_op,
                pop_pc, int_enable, sleep_op, watchdog_kick);
   modport use_side (output word, input alu_func, src_literal, dest_file, dest_acc,
                upd_zero, upd_carry, upd_dc, skip_on_zero, bit_test, test_set, jump_op,
                call_op, pop_pc, int_enable, sleep_op, watchdog_kick);
endinterface

// ---- mid_word_decode.sv ----
`timescale 1ns/1ps
`include "mid_params.svh"

module mid_word_decode (
   mid_dec_if.dec dec
);
   import mid_pkg::*;

   // Byte opcode to ALU function; shared by both destination cases
   function automatic mid_alu_type byte_func(input logic [3:0] op);
      case (op)
         4'h1: byte_func = MID_ALU_CLEAR;
         4'h2: byte_func = MID_ALU_SUB;
         4'h3: byte_func = MID_ALU_DEC;
         4'h4: byte_func = MID_ALU_OR;
         4'h5: byte_func = MID_ALU_AND;
         4'h6: byte_func = MID_ALU_XOR;
         4'h7: byte_func = MID_ALU_ADD;
         4'h8: byte_func = MID_ALU_MOVE;
         4'h9: byte_func = MID_ALU_COM;
         4'ha: byte_func = MID_ALU_INC;
         4'hb: byte_func = MID_ALU_DEC;
         4'hc: byte_func = MID_ALU_RR;
         4'hd: byte_func = MID_ALU_RL;
         4'he: byte_func = MID_ALU_SWAP;
         4'hf: byte_func = MID_ALU_INC;
         default: byte_func = MID_ALU_NONE;
      endcase
   endfunction

   // ************************************************************
   // Field split
   // ************************************************************
   wire [1:0] cls      = dec.word[`MID_CLASS_HI:`MID_CLASS_LO];
   wire [3:0] op4      = dec.word[`MID_OP_HI:`MID_OP_LO];
   wire       dbit     = dec.word[`MID_DEST_BIT];
   wire       is_byte  = (cls == `MID_CLASS_BYTE);
   wire       is_bit   = (cls == `MID_CLASS_BIT);
   wire       is_jmp   = (cls == `MID_CLASS_JUMP);
   wire       is_lit   = (cls == `MID_CLASS_LIT);
   wire       byte_ctl = is_byte && (op4 == 4'h0);
   wire       is_store = byte_ctl && dbit;
   // Fixed words compare the whole word, so no don't-care bit is involved
   wire       w_ret    = (dec.word == `MID_WORD_RET);
   wire       w_retie  = (dec.word == `MID_WORD_RETIE);
   wire       w_sleep  = (dec.word == `MID_WORD_SLEEP);
   wire       w_wdt    = (dec.word == `MID_WORD_WDT);

   // Literal group: x bits never reach the compare; the x-bit forms use only op4[3:1] or [3:2]
   wire lit_load = is_lit && (op4[3:2] == 2'h0);                  // [RULE_03] [RULE_13]
   wire lit_ret  = is_lit && (op4[3:2] == 2'h1);                  // [RULE_13]
   wire lit_or   = is_lit && (op4 == 4'h8);                       // [RULE_12]
   wire lit_and  = is_lit && (op4 == 4'h9);                       // [RULE_12]
   wire lit_xor  = is_lit && (op4 == 4'ha);                       // [RULE_12]
   wire lit_sub  = is_lit && (op4[3:1] == 3'h6);                  // [RULE_03] [RULE_11]
   wire lit_add  = is_lit && (op4[3:1] == 3'h7);                  // [RULE_11]
   wire bit_wr   = is_bit && !op4[3];                             // [RULE_08]
   wire byte_op  = is_byte && !byte_ctl;                          // [RULE_04]
   wire arith    = (byte_op && ((op4 == 4'h7) || (op4 == 4'h2))) || lit_add || lit_sub;

   // ************************************************************
   // ALU function and destination
   // ************************************************************
   assign dec.alu_func =
      byte_op  ? byte_func(op4) :                                 // [RULE_05] [RULE_06] [RULE_18]
      is_store ? MID_ALU_PASS_ACC :
      bit_wr   ? (op4[2] ? MID_ALU_BIT_SET : MID_ALU_BIT_CLR) :  // [RULE_08]
      (lit_load || lit_ret) ? MID_ALU_LOAD_LIT :
      lit_or   ? MID_ALU_OR  :
      lit_and  ? MID_ALU_AND :
      lit_xor  ? MID_ALU_XOR :
      lit_sub  ? MID_ALU_SUB :                                    // Literal minus accumulator
      lit_add  ? MID_ALU_ADD : MID_ALU_NONE;
   assign dec.src_literal = is_lit;
   // Clear with d=0 clears the accumulator, d=1 the file
   assign dec.dest_file   = (byte_op && dbit) || is_store || bit_wr;    // [RULE_02]
   assign dec.dest_acc    = (byte_op && !dbit) || (is_lit && (dec.alu_func != MID_ALU_NONE));
   assign dec.upd_carry   = arith || (byte_op && (op4[3:1] == 3'h6)); // [RULE_06]
   assign dec.upd_dc      = arith;
   assign dec.upd_zero    = arith || lit_or || lit_and || lit_xor ||
                            (byte_op && (op4 != 4'hb) && (op4 != 4'hf) && (op4[3:1] != 3'h6)
                             && (op4 != 4'he));                        // [RULE_05] [RULE_12]
   assign dec.skip_on_zero = byte_op && (op4[1:0] == 2'h3) && op4[3]; // [RULE_07]
   assign dec.bit_test     = is_bit && op4[3];                         // [RULE_09]
   assign dec.test_set     = op4[2];
   assign dec.jump_op      = is_jmp;                                   // [RULE_10]
   assign dec.call_op      = is_jmp && !dec.word[`MID_JUMP_SEL];
   assign dec.pop_pc       = w_ret || w_retie || lit_ret;              // [RULE_19] [RULE_13]
   assign dec.int_enable   = w_retie;
   assign dec.sleep_op     = w_sleep;                                  // [RULE_14]
   assign dec.watchdog_kick = w_wdt;

endmodule

// ---- mid_prog_mem.sv ----
`timescale 1ns/1ps

// Program memory stand-in feeding one word per fetch
module mid_prog_mem (
   input  wire logic        clk,
   input  wire logic [13:0] fetch_word,
   input  wire logic        fetch_en,
   output logic [13:0]      instr_word,
   output logic             instr_valid
);
   logic [13:0] last_reg = 14'h0000;  // Known start, so an idle first cycle is not unknown
   // A released bus shows the inverse of the last word, so stale data never decodes by luck
   always_ff @(posedge clk) if (fetch_en) last_reg <= fetch_word;
   assign instr_valid = fetch_en;
   assign instr_word  = fetch_en ? fetch_word : ~last_reg;
endmodule

// ---- tb_mcu14_instruction_decoder.sv ----
`timescale 1ns/1ps

module tb_mcu14_instruction_decoder;
   import mid_pkg::*;
   typedef struct packed {
      mid_alu_type alu;
      logic        df, da, uz, uc, udc, sk, nop, jp, pu, po, ie, sl, wk, tw, pw, pv, pc, sr;
      logic [7:0]  lit;
      logic [6:0]  fa;
      logic [2:0]  bi;
      logic [1:0]  cy;
      logic [7:0]  opr;
      logic [10:0] tgt;
   } mid_exp_type;
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        fetch_en = 1'b0;
   logic        io = 1'b0;
   logic        ps = 1'b0;
   logic        flush = 1'b0;
   logic [13:0] fetch_word = 14'h0000;
   logic [13:0] last_w = 14'h0000;
   logic [7:0]  latch = 8'h00;
   logic [7:0]  pins = 8'h00;
   logic [13:0] instr_word;
   logic        instr_valid;
   logic [13:0] fixed [4] = '{14'h0008, 14'h0009, 14'h0063, 14'h0064};
   wire logic   pd_val;
   wire mid_exp_type seen;
   mid_exp_type exp_q[$];
   int          fail_count = 0;
   int          check_count = 0;

   mid_prog_mem u_mem (.clk(clk), .fetch_word(fetch_word), .fetch_en(fetch_en),
      .instr_word(instr_word), .instr_valid(instr_valid));
   mid_decoder u_dut (.clk(clk), .sys_rst(sys_rst), .instr_word(instr_word),
      .instr_valid(instr_valid), .file_latch_data(latch), .file_pin_data(pins),
      .file_is_io(io), .prescaler_on_timer(ps), .alu_func_reg(seen.alu),
      .src_literal_reg(seen.sr), .operand_reg(seen.opr), .literal_reg(seen.lit),
      .file_addr_reg(seen.fa), .bit_idx_reg(seen.bi), .dest_file_reg(seen.df),
      .dest_acc_reg(seen.da),
      .upd_zero_reg(seen.uz), .upd_carry_reg(seen.uc), .upd_dc_reg(seen.udc),
      .skip_reg(seen.sk), .nop_cycle_reg(seen.nop), .jump_reg(seen.jp), .push_reg(seen.pu),
      .pop_reg(seen.po), .int_enable_reg(seen.ie), .target_reg(seen.tgt),
      .cycles_reg(seen.cy), .sleep_req_reg(seen.sl), .watchdog_kick_reg(seen.wk),
      .timeout_flag_wr_reg(seen.tw), .powerdown_flag_wr_reg(seen.pw),
      .powerdown_flag_val_reg(pd_val), .prescaler_clr_reg(seen.pc));
   assign seen.pv = seen.pw & pd_val;

   // 200 MHz
   always #2.5 clk = ~clk;

   // Reference decode of one word with the operand presented beside it
   function automatic mid_exp_type exp_of(logic [13:0] w, logic [7:0] v, logic p);
      mid_exp_type e;
      logic [3:0]  op;
      e = '0;
      op = w[11:8];
      e.opr = v;
      e.tgt = w[10:0];
      e.lit = w[7:0];
      e.fa = w[6:0];
      e.bi = w[9:7];
      e.po = (w[13:1] == 13'h0004);
      e.ie = (w == 14'h0009);
      e.sl = (w == 14'h0063);
      e.wk = (w == 14'h0064);
      e.tw = e.sl | e.wk;
      e.pw = e.tw;
      e.pv = e.wk;
      case (w[13:12])
         2'h0: if (op != 4'h0) begin
            e.df = w[7];
            e.da = !w[7];
            case (op)
               4'h7: e.alu = MID_ALU_ADD;
               4'h2: e.alu = MID_ALU_SUB;
               4'h4: e.alu = MID_ALU_OR;
               4'h6: e.alu = MID_ALU_XOR;
               4'h5: e.alu = MID_ALU_AND;
               4'hd: e.alu = MID_ALU_RL;
               4'hc: e.alu = MID_ALU_RR;
               4'hb: e.alu = MID_ALU_DEC;
               default: e.alu = MID_ALU_INC;
            endcase
            e.uz = op inside {4'h7, 4'h2, 4'h4, 4'h6, 4'h5};
            e.uc = op inside {4'h7, 4'h2, 4'hd, 4'hc};
            e.udc = op inside {4'h7, 4'h2};
            e.sk = (op == 4'hb && v == 8'h01) || (op == 4'hf && v == 8'hff);
            e.pc = w[7] && w[6:0] == 7'h01 && p;
         end
         2'h1: begin
            e.alu = op[3] ? MID_ALU_NONE : op[2] ? MID_ALU_BIT_SET : MID_ALU_BIT_CLR;
            e.df = !op[3];
            e.pc = !op[3] && w[6:0] == 7'h01 && p;
            e.sk = op[3] && (v[w[9:7]] == op[2]);
         end
         2'h2: begin
            e.jp = 1'b1;
            e.pu = !w[11];
         end
         default: begin
            case (op[3:2])
               2'h2: e.alu = op[1:0] == 2'h0 ? MID_ALU_OR : op[1:0] == 2'h1 ? MID_ALU_AND
                  : op[1:0] == 2'h2 ? MID_ALU_XOR : MID_ALU_NONE;
               2'h3: e.alu = op[1] ? MID_ALU_ADD : MID_ALU_SUB;
               default: e.alu = MID_ALU_LOAD_LIT;
            endcase
            e.da = op != 4'hb;
            e.sr = 1'b1;
            e.po = op[3:2] == 2'h1;
            e.uz = op[3] && op != 4'hb;
            e.uc = op[3:2] == 2'h3;
            e.udc = e.uc;
         end
      endcase
      e.cy = (e.sk || e.jp || e.po) ? 2'h2 : 2'h1;
      return e;
   endfunction

   // Present one fetch just after the edge and note the result due a cycle later
   task automatic step(logic en, logic [13:0] w);
      mid_exp_type e;
      mid_exp_type s;
      logic        nf;
      @(posedge clk);
      #1;
      fetch_en = en;
      fetch_word = w;
      latch = ($urandom % 3 == 0) ? 8'h01 : ($urandom % 2) ? 8'hff : 8'($urandom);
      pins = latch ^ 8'hfe;
      io = 1'($urandom % 2);
      ps = 1'($urandom % 2);
      e = exp_of(en ? w : ~last_w, io ? pins : latch, ps);
      if (en) last_w = w;
      nf = en && !flush && e.cy == 2'h2;
      // A dropped or absent word leaves only the data fields and the cycle count; a dropped one also sets the no-op mark
      if (!en || flush) begin
         s = '0;
         s.opr = e.opr;
         s.tgt = e.tgt;
         s.lit = e.lit;
         s.fa = e.fa;
         s.bi = e.bi;
         s.cy = e.cy;
         s.nop = flush;
         e = s;
      end
      flush = nf;
      exp_q.push_back(e);
   endtask

   // Two notes queued means the older one is due now
   always @(posedge clk) begin
      #3;
      if (exp_q.size() > 1) begin
         check_count++;
         if (seen !== exp_q[0]) begin
            fail_count++;
            $display("mismatch decode expected %h seen %h", exp_q[0], seen);
         end
         void'(exp_q.pop_front());
      end
   end

   task automatic conclude();
      if (fail_count == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Reset, then a long run of random legal words with boundary operands
   initial begin
      mid_exp_type r;
      logic [13:0] w;
      void'($urandom(32'h40bd));
      r = '0;
      r.cy = 2'h1;
      repeat (5) @(posedge clk);
      #1;
      check_count++;
      if (seen !== r) begin
         fail_count++;
         $display("mismatch reset expected %h seen %h", r, seen);
      end
      sys_rst = 1'b0;
      for (int i = 0; i < 800; i++) begin
         w = 14'($urandom);
         if ($urandom % 4 == 0) w[6:0] = 7'h01;
         if (w[13:12] == 2'h0 && !(w[11:8] inside {4'h2, 4'h4, 4'h5, 4'h6, 4'h7, 4'hb,
             4'hc, 4'hd, 4'hf})) w = fixed[w[1:0]];
         step($urandom % 8 != 0, w);
      end
      step(1'b0, 14'h0000);
      repeat (2) @(posedge clk);
      conclude();
   end
endmodule
